//--- rtl/gppo_pkg.sv
// Purpose: shared constants and types of the grouped pulse pattern output
// Assumes: 32-bit axi4-lite register bus, 100 MHz aclk
// Notes: byte offsets of all registers live here
package gppo_pkg;
  localparam int GPPO_NGRP = 4;
  localparam int GPPO_GW = 4;
  localparam int GPPO_TW = 16;
  localparam int GPPO_AW = 8;
  // register byte offsets
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_TRIG = 8'h04;
  localparam logic [7:0] OFS_OE_HI = 8'h08;
  localparam logic [7:0] OFS_OE_LO = 8'h0c;
  localparam logic [7:0] OFS_NXT_HI = 8'h10;
  localparam logic [7:0] OFS_NXT_LO = 8'h14;
  localparam logic [7:0] OFS_CUR_HI = 8'h18;
  localparam logic [7:0] OFS_CUR_LO = 8'h1c;
  localparam logic [7:0] OFS_RUN = 8'h20;
  localparam logic [7:0] OFS_IEN = 8'h24;
  localparam logic [7:0] OFS_FLG = 8'h28;
  localparam logic [7:0] OFS_DIR_HI = 8'h2c;
  localparam logic [7:0] OFS_DIR_LO = 8'h30;
  // compare block: 0x40 + 8*ch, a at +0, b at +4
  localparam logic [2:0] CMP_PAGE = 3'b010;
  localparam int CMP_CH_LSB = 3;
  localparam int CMP_SEL_BIT = 2;
  // reset values
  localparam logic [7:0] RST_TRIG = 8'he4;
  localparam logic [15:0] RST_CMP = 16'hffff;
  localparam logic [15:0] RST_CNT = 16'h0000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic [GPPO_TW-1:0] a;
    logic [GPPO_TW-1:0] b;
  } gppo_cmp_t;

  typedef struct packed {
    logic match_a;
    logic match_b;
  } gppo_evt_t;

  typedef enum logic {
    NOV_IDLE = 1'b0,
    NOV_WAIT = 1'b1
  } gppo_nov_t;
endpackage

//--- rtl/gppo_timer.sv
// Purpose: one companion timer channel with compare a and b
// Assumes: counts every aclk while run is high
// Notes: compare b clears the counter, so the period is b+1 cycles
`timescale 1ns/1ps
module gppo_timer
  import gppo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // control
  input wire logic run,
  input wire gppo_cmp_t cmp,
  input wire logic clr_a,
  input wire logic clr_b,
  // status
  output gppo_evt_t evt,
  output logic flag_a,
  output logic flag_b
);
  logic [GPPO_TW-1:0] cnt_q;
  logic flag_a_q;
  logic flag_b_q;

  assign evt.match_a = run && (cnt_q == cmp.a);
  assign evt.match_b = run && (cnt_q == cmp.b);
  assign flag_a = flag_a_q;
  assign flag_b = flag_b_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_q <= RST_CNT;
    end
    else if (evt.match_b)
    begin
      cnt_q <= RST_CNT;
    end
    else if (run)
    begin
      cnt_q <= cnt_q + GPPO_TW'(1);
    end
  end

  // set wins over a clear in the same cycle
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      flag_a_q <= 1'b0;
      flag_b_q <= 1'b0;
    end
    else
    begin
      flag_a_q <= evt.match_a | (flag_a_q & ~clr_a);
      flag_b_q <= evt.match_b | (flag_b_q & ~clr_b);
    end
  end
endmodule

//--- rtl/gppo_group.sv
// Purpose: one 4-bit pattern group with normal and non-overlap update
// Assumes: trig_b and trig_a are one-cycle pulses of the selected timer
// Notes: in non-overlap mode falling bits change at b, rising bits at a
`timescale 1ns/1ps
module gppo_group
  import gppo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // triggers and setup
  input wire logic trig_b,
  input wire logic trig_a,
  input wire logic nonoverlap,
  input wire logic [GPPO_GW-1:0] en,
  input wire logic [GPPO_GW-1:0] nxt,
  // software preload
  input wire logic sw_we,
  input wire logic [GPPO_GW-1:0] sw_data,
  // pattern
  output logic [GPPO_GW-1:0] cur
);
  gppo_nov_t st_q;
  gppo_nov_t st_d;
  logic [GPPO_GW-1:0] cur_q;
  logic [GPPO_GW-1:0] cur_d;
  logic [GPPO_GW-1:0] pend_q;
  logic [GPPO_GW-1:0] pend_d;
  logic [GPPO_GW-1:0] base;

  assign cur = cur_q;

  always_comb
  begin
    base = sw_we ? sw_data : cur_q;
    st_d = st_q;
    pend_d = pend_q;
    case (st_q)
      NOV_WAIT:
      begin
        if (trig_a)
        begin
          base = base | pend_q;
          st_d = NOV_IDLE;
        end
      end
      default:
      begin
      end
    endcase
    cur_d = base;
    if (trig_b)
    begin
      if (nonoverlap)
      begin
        cur_d = base & ~(en & ~nxt);
        pend_d = en & nxt & ~base;
        st_d = NOV_WAIT;
      end
      else
      begin
        cur_d = (base & ~en) | (nxt & en);
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_q <= NOV_IDLE;
      cur_q <= '0;
      pend_q <= '0;
    end
    else
    begin
      st_q <= st_d;
      cur_q <= cur_d;
      pend_q <= pend_d;
    end
  end
endmodule

//--- rtl/gppo_top.sv
// Purpose: grouped pulse pattern output with four companion timers
// Assumes: axi4-lite slave, single clock, synchronous active-low reset
// Notes: reads answer one cycle after they are taken, writes two cycles after
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module gppo_top
  import gppo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [GPPO_AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // axi4-lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // axi4-lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // axi4-lite read
  input wire logic arvalid,
  output logic arready,
  input wire logic [GPPO_AW-1:0] araddr,
  input wire logic [2:0] arprot,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // pattern pins
  output logic [15:0] pattern_out_pins,
  output logic [15:0] pattern_out_oe,
  // compare a interrupt per timer
  output logic [GPPO_NGRP-1:0] compare_a_irq
);
  // register state
  logic [GPPO_NGRP-1:0] overlap_mode_select_q;
  logic [7:0] group_trigger_select_q;
  logic [7:0] upper_output_enable_q;
  logic [7:0] lower_output_enable_q;
  logic [7:0] upper_next_pattern_q;
  logic [7:0] lower_next_pattern_q;
  logic [7:0] upper_port_direction_q;
  logic [7:0] lower_port_direction_q;
  logic [GPPO_NGRP-1:0] timer_run_control_q;
  logic [GPPO_NGRP-1:0] timer_irq_enable_q;
  gppo_cmp_t cmp_q [GPPO_NGRP];

  // bus state
  logic aw_full_q;
  logic [GPPO_AW-1:0] aw_addr_q;
  logic w_full_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;

  // block status
  logic [15:0] cur_pat;
  logic [GPPO_NGRP-1:0] flg_a;
  logic [GPPO_NGRP-1:0] flg_b;
  gppo_evt_t evt [GPPO_NGRP];

  function automatic logic addr_hit(input logic [GPPO_AW-1:0] a);
    logic [GPPO_AW-1:0] w;
    w = {a[GPPO_AW-1:2], 2'b00};
    addr_hit = (w == OFS_MODE) || (w == OFS_TRIG) || (w == OFS_OE_HI) ||
      (w == OFS_OE_LO) || (w == OFS_NXT_HI) || (w == OFS_NXT_LO) ||
      (w == OFS_CUR_HI) || (w == OFS_CUR_LO) || (w == OFS_RUN) ||
      (w == OFS_IEN) || (w == OFS_FLG) || (w == OFS_DIR_HI) ||
      (w == OFS_DIR_LO) || (w[7:5] == CMP_PAGE);
  endfunction

  function automatic logic [31:0] rd_mux(input logic [GPPO_AW-1:0] a);
    logic [GPPO_AW-1:0] w;
    logic [1:0] ch;
    w = {a[GPPO_AW-1:2], 2'b00};
    ch = a[CMP_CH_LSB+1:CMP_CH_LSB];
    rd_mux = 32'h0000_0000;
    if (w[7:5] == CMP_PAGE)
    begin
      rd_mux[15:0] = a[CMP_SEL_BIT] ? cmp_q[ch].b : cmp_q[ch].a;
    end
    else
    begin
      case (w)
        OFS_MODE: rd_mux[3:0] = overlap_mode_select_q;
        OFS_TRIG: rd_mux[7:0] = group_trigger_select_q;
        OFS_OE_HI: rd_mux[7:0] = upper_output_enable_q;
        OFS_OE_LO: rd_mux[7:0] = lower_output_enable_q;
        OFS_NXT_HI: rd_mux[7:0] = upper_next_pattern_q;
        OFS_NXT_LO: rd_mux[7:0] = lower_next_pattern_q;
        OFS_CUR_HI: rd_mux[7:0] = cur_pat[15:8];
        OFS_CUR_LO: rd_mux[7:0] = cur_pat[7:0];
        OFS_RUN: rd_mux[3:0] = timer_run_control_q;
        OFS_IEN: rd_mux[3:0] = timer_irq_enable_q;
        OFS_FLG: rd_mux[7:0] = {flg_b, flg_a};
        OFS_DIR_HI: rd_mux[7:0] = upper_port_direction_q;
        OFS_DIR_LO: rd_mux[7:0] = lower_port_direction_q;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  endfunction

  // write path decode
  wire do_wr = aw_full_q && w_full_q && !bvalid_q;
  wire [GPPO_AW-1:0] wa = {aw_addr_q[GPPO_AW-1:2], 2'b00};
  wire [31:0] bmask = {{8{w_strb_q[3]}}, {8{w_strb_q[2]}},
    {8{w_strb_q[1]}}, {8{w_strb_q[0]}}};
  logic [31:0] wr_old;
  // old register value, so the merge follows every register change
  always_comb
  begin
    wr_old = rd_mux(aw_addr_q);
  end
  wire [31:0] wv = (wr_old & ~bmask) | (w_data_q & bmask);
  wire we_mode = do_wr && (wa == OFS_MODE);
  wire we_trig = do_wr && (wa == OFS_TRIG);
  wire we_oe_hi = do_wr && (wa == OFS_OE_HI);
  wire we_oe_lo = do_wr && (wa == OFS_OE_LO);
  wire we_nxt_hi = do_wr && (wa == OFS_NXT_HI);
  wire we_nxt_lo = do_wr && (wa == OFS_NXT_LO);
  wire we_cur_hi = do_wr && (wa == OFS_CUR_HI);
  wire we_cur_lo = do_wr && (wa == OFS_CUR_LO);
  wire we_run = do_wr && (wa == OFS_RUN);
  wire we_ien = do_wr && (wa == OFS_IEN);
  wire we_flg = do_wr && (wa == OFS_FLG);
  wire we_dir_hi = do_wr && (wa == OFS_DIR_HI);
  wire we_dir_lo = do_wr && (wa == OFS_DIR_LO);
  wire we_cmp = do_wr && (wa[7:5] == CMP_PAGE);
  wire [1:0] wch = aw_addr_q[CMP_CH_LSB+1:CMP_CH_LSB];
  wire wsel_b = aw_addr_q[CMP_SEL_BIT];
  wire [GPPO_NGRP-1:0] clr_a = we_flg ? wv[3:0] : 4'h0;
  wire [GPPO_NGRP-1:0] clr_b = we_flg ? wv[7:4] : 4'h0;
  wire rd_take = arvalid && !rvalid_q;

  // handshakes
  assign awready = !aw_full_q;
  assign wready = !w_full_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = !rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
    end
    else if (awvalid && !aw_full_q)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= awaddr;
    end
    else if (do_wr)
    begin
      aw_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_data_q <= '0;
      w_strb_q <= '0;
    end
    else if (wvalid && !w_full_q)
    begin
      w_full_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end
    else if (do_wr)
    begin
      w_full_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
    end
    else if (do_wr)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_hit(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bready)
    begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
    end
    else if (rd_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux(araddr);
      rresp_q <= addr_hit(araddr) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // control registers
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overlap_mode_select_q <= '0;
      group_trigger_select_q <= RST_TRIG;
      upper_output_enable_q <= '0;
      lower_output_enable_q <= '0;
      upper_next_pattern_q <= '0;
      lower_next_pattern_q <= '0;
      upper_port_direction_q <= '0;
      lower_port_direction_q <= '0;
      timer_run_control_q <= '0;
      timer_irq_enable_q <= '0;
    end
    else
    begin
      if (we_mode) overlap_mode_select_q <= wv[3:0];
      if (we_trig) group_trigger_select_q <= wv[7:0];
      if (we_oe_hi) upper_output_enable_q <= wv[7:0];
      if (we_oe_lo) lower_output_enable_q <= wv[7:0];
      if (we_nxt_hi) upper_next_pattern_q <= wv[7:0];
      if (we_nxt_lo) lower_next_pattern_q <= wv[7:0];
      if (we_dir_hi) upper_port_direction_q <= wv[7:0];
      if (we_dir_lo) lower_port_direction_q <= wv[7:0];
      if (we_run) timer_run_control_q <= wv[3:0];
      if (we_ien) timer_irq_enable_q <= wv[3:0];
    end
  end

  wire [15:0] en_all = {upper_output_enable_q, lower_output_enable_q};
  wire [15:0] nxt_all = {upper_next_pattern_q, lower_next_pattern_q};
  wire [15:0] cur_wdat = {wv[7:0], wv[7:0]};
  wire [15:0] cur_we = {{8{we_cur_hi}}, {8{we_cur_lo}}};

  // driven only where direction is output
  assign pattern_out_pins = cur_pat;
  assign pattern_out_oe = {upper_port_direction_q, lower_port_direction_q};
  assign compare_a_irq = flg_a & timer_irq_enable_q;

  genvar g;
  generate
    for (g = 0; g < GPPO_NGRP; g++)
    begin : gen_ch
      wire [1:0] sel = group_trigger_select_q[2*g+1:2*g];

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          cmp_q[g] <= {RST_CMP, RST_CMP};
        end
        else if (we_cmp && (wch == 2'(g)))
        begin
          if (wsel_b) cmp_q[g].b <= wv[15:0];
          else cmp_q[g].a <= wv[15:0];
        end
      end

      gppo_timer u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .run(timer_run_control_q[g]),
        .cmp(cmp_q[g]),
        .clr_a(clr_a[g]),
        .clr_b(clr_b[g]),
        .evt(evt[g]),
        .flag_a(flg_a[g]),
        .flag_b(flg_b[g])
      );

      gppo_group u_grp (
        .aclk(aclk),
        .aresetn(aresetn),
        .trig_b(evt[sel].match_b),
        .trig_a(evt[sel].match_a),
        .nonoverlap(overlap_mode_select_q[g]),
        .en(en_all[4*g+3:4*g]),
        .nxt(nxt_all[4*g+3:4*g]),
        .sw_we(cur_we[4*g]),
        .sw_data(cur_wdat[4*g+3:4*g]),
        .cur(cur_pat[4*g+3:4*g])
      );
    end
  endgenerate
endmodule

//--- tb/gppo_sva.sv
// Purpose: bus and pin timing checks on the pattern output block
// Assumes: single clock domain, synchronous active-low reset
// Notes: sees only the top-level ports
`timescale 1ns/1ps
module gppo_sva
  import gppo_pkg::*;
(
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // register bus
  input wire logic awready,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  // pins
  input wire logic [15:0] pattern_out_pins,
  input wire logic [15:0] pattern_out_oe,
  input wire logic [GPPO_NGRP-1:0] compare_a_irq
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  chk_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  chk_r_holds: assert property (rvalid && !rready |=> rvalid && $stable({rresp, rdata}))
    else $error("read data dropped early");
  chk_ar_blocked: assert property (rvalid |-> !arready)
    else $error("read address accepted while data pending");
  chk_rd_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  chk_err_zero: assert property (rvalid && rresp == RESP_SLVERR |-> rdata == 32'h0)
    else $error("error read returns data");
  chk_b_after_both: assert property ($rose(bvalid) |-> $past(!awready && !wready))
    else $error("write answered without address and data held");
  chk_oe_by_write: assert property ($changed(pattern_out_oe) |-> $rose(bvalid))
    else $error("pin direction changed without a write");
  chk_quiet_start: assert property ($rose(aresetn) |->
    pattern_out_pins == 16'h0 && pattern_out_oe == 16'h0 && compare_a_irq == 4'h0)
    else $error("outputs not idle after reset");
endmodule

bind gppo_top gppo_sva u_gppo_sva (.aclk, .aresetn, .awready, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .pattern_out_pins,
  .pattern_out_oe, .compare_a_irq);

//--- tb/gppo_load.sv
// Purpose: load on the pattern pins, counts overlapping transitions
// Assumes: a pin that is not driven is pulled low by the load
// Notes: a clash is one pin rising while another falls in one cycle
`timescale 1ns/1ps
module gppo_load
(
  // clock
  input wire logic aclk,
  // pins from the block
  input wire logic [15:0] pins,
  input wire logic [15:0] oe,
  // observation
  output int clash,
  output int gap
);
  logic [15:0] lvl;
  logic [15:0] prev = 16'h0;
  int cyc = 0;
  int t_fall = 0;
  assign lvl = pins & oe;
  initial clash = 0;
  initial gap = 0;
  always @(negedge aclk)
  begin
    if ((|(lvl & ~prev)) && (|(prev & ~lvl)))
      clash <= clash + 1;
    // cycles from the last falling pin to the next rising one
    cyc <= cyc + 1;
    if (|(prev & ~lvl))
      t_fall <= cyc;
    if (|(lvl & ~prev))
      gap <= cyc - t_fall;
    prev <= lvl;
  end
endmodule

//--- tb/gppo_tb_top.sv
// Purpose: self-checking bench of the pattern output block
// Assumes: axi4-lite master tasks, compare b of 9 gives 10-cycle periods
// Notes: bus answers are checked from queues by a negedge monitor
`timescale 1ns/1ps
module gppo_tb_top
  import gppo_pkg::*;
;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 0, araddr = 0, nl, nh, lo, hi;
  logic [31:0] wdata = 0, rdata, seed = 32'h00011bb2;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [15:0] pattern_out_pins, pattern_out_oe;
  logic [3:0] compare_a_irq;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int fails = 0, cmp_count = 0, clash, gap, c0;

  always #5 aclk = ~aclk;

  gppo_top u_gppo_top (.aclk, .aresetn, .awvalid, .awready, .awaddr, .awprot(3'h0), .wvalid,
    .wready, .wdata, .wstrb(4'hf), .bvalid, .bready, .bresp, .arvalid, .arready, .araddr,
    .arprot(3'h0), .rvalid, .rready, .rdata, .rresp, .pattern_out_pins, .pattern_out_oe,
    .compare_a_irq);
  gppo_load u_gppo_load (.aclk, .pins(pattern_out_pins), .oe(pattern_out_oe), .clash, .gap);

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task wrap_up;
    // a note never answered counts as a mismatch
    fails += bq.size() + rq.size();
    $display("compares %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic aw, w, b;
    bq.push_back(r);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      aw = awvalid && awready;
      w = wvalid && wready;
      b = bvalid && bready;
      @(posedge aclk);
      if (aw)
        awvalid <= 1'b0;
      if (w)
        wvalid <= 1'b0;
      if (b)
      begin
        bready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    logic ar, b;
    rq.push_back({r, d});
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever
    begin
      @(negedge aclk);
      ar = arvalid && arready;
      b = rvalid && rready;
      @(posedge aclk);
      if (ar)
        arvalid <= 1'b0;
      if (b)
      begin
        rready <= 1'b0;
        break;
      end
    end
  endtask

  task automatic phase(input logic [3:0] ch, input logic [7:0] h, input logic [7:0] l);
    wr(OFS_NXT_HI, {24'h0, h}, RESP_OKAY);
    wr(OFS_NXT_LO, {24'h0, l}, RESP_OKAY);
    wr(OFS_RUN, {28'h0, ch}, RESP_OKAY);
    repeat (30) @(posedge aclk);
    wr(OFS_RUN, 32'h0, RESP_OKAY);
  endtask

  task automatic pchk;
    @(negedge aclk);
    chk(34'(pattern_out_pins), 34'({hi, lo}));
    rd(OFS_CUR_HI, {24'h0, hi}, RESP_OKAY);
    rd(OFS_CUR_LO, {24'h0, lo}, RESP_OKAY);
  endtask

  // answer monitor: oldest note against each accepted response
  always @(negedge aclk)
  begin
    if (bvalid && bready)
      chk({32'h0, bresp}, {32'h0, bq.pop_front()});
    if (rvalid && rready)
      chk({rresp, rdata}, rq.pop_front());
  end

  initial
  begin
    repeat (3000) @(posedge aclk);
    fails++;
    wrap_up;
  end

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFS_TRIG, {24'h0, RST_TRIG}, RESP_OKAY);
    rd(8'h40, {16'h0, RST_CMP}, RESP_OKAY);
    rd(8'h3c, 32'h0, RESP_SLVERR);
    wr(8'h3c, 32'hffffffff, RESP_SLVERR);
    wr(OFS_DIR_HI, 32'hff, RESP_OKAY);
    wr(OFS_DIR_LO, 32'hff, RESP_OKAY);
    wr(OFS_CUR_HI, 32'hc3, RESP_OKAY);
    wr(OFS_CUR_LO, 32'h5a, RESP_OKAY);
    wr(OFS_OE_HI, 32'h0f, RESP_OKAY);
    wr(OFS_OE_LO, 32'hff, RESP_OKAY);
    wr(OFS_IEN, 32'hf, RESP_OKAY);
    for (int ch = 0; ch < 4; ch++)
    begin
      wr(8'(8'h40 + 8 * ch), 32'd2, RESP_OKAY);
      wr(8'(8'h44 + 8 * ch), 32'd9, RESP_OKAY);
    end
    @(negedge aclk);
    chk(34'(pattern_out_oe), 34'(16'hffff));
    hi = 8'hc3;
    lo = 8'h5a;
    pchk;
    // channel 1 alone moves only group 1 under the reset selection
    seed = lfsr(seed);
    nl = seed[7:0];
    seed = lfsr(seed);
    nh = seed[7:0];
    phase(4'b0010, nh, nl);
    lo = {nl[7:4], 4'ha};
    pchk;
    // all groups on channel 0, upper nibble of the top byte disabled
    wr(OFS_TRIG, 32'h0, RESP_OKAY);
    seed = lfsr(seed);
    nl = seed[7:0];
    seed = lfsr(seed);
    nh = seed[7:0];
    phase(4'b0001, nh, nl);
    lo = nl;
    hi = {4'hc, nh[3:0]};
    pchk;
    // non-overlap: every enabled bit flips, no rise may meet a fall
    wr(OFS_MODE, 32'hf, RESP_OKAY);
    c0 = clash;
    phase(4'b0001, ~hi, ~lo);
    lo = ~lo;
    hi = {4'hc, ~hi[3:0]};
    pchk;
    chk(34'(clash), 34'(c0));
    // rises follow the fall by compare a plus one cycles
    chk(34'(gap), 34'(2 + 1));
    rd(OFS_FLG, 32'h33, RESP_OKAY);
    @(negedge aclk);
    chk(34'(compare_a_irq), 34'(4'b0011));
    wr(OFS_FLG, 32'hff, RESP_OKAY);
    rd(OFS_FLG, 32'h0, RESP_OKAY);
    @(negedge aclk);
    chk(34'(compare_a_irq), 34'(4'b0000));
    wrap_up;
  end
endmodule
